// ### logic/isab_pkg.sv
/*
 Package for the ISA bus cycle interface: timing counts, cycle kinds,
 and the packed request and status carriers.
 Assumes a 200 MHz core clock.
*/
`default_nettype none
package isab_pkg;
   localparam int CLK_MHZ = 200;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int BCLK_NS = 120;
   localparam int BCLK_HALF_CYC = BCLK_NS / 2 * CLK_MHZ / 1000;
   localparam int OSC_MHZ = 14;
   localparam int TIMER_DIV = 12;
   localparam int ALE_NS = 60;
   localparam int ALE_CYC = (ALE_NS * CLK_MHZ + 999) / 1000;
   localparam int READY_NS = 480;
   localparam int READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
   localparam logic [23:0] LOW_MEG_LIMIT = 24'h100000;
   localparam logic [2:0] ST_RESET = 3'h0;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      KIND_MEM_RD = 2'b00,
      KIND_MEM_WR = 2'b01,
      KIND_IO_RD = 2'b10,
      KIND_IO_WR = 2'b11
   } isab_kind_t;
   typedef struct packed {
      logic dma;
      isab_kind_t kind;
      logic [23:0] addr;
      logic wide;
      logic hi_lane;
      logic [15:0] wdata;
   } isab_req_t;
   typedef struct packed {
      logic done;
      logic width16;
      logic err;
      logic [15:0] rdata;
   } isab_rsp_t;
endpackage
`default_nettype wire

// ### logic/isab_sync.sv
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes inputs asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module isab_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta[i] <= 1'b1;
               q[i] <= 1'b1;
            end else begin
               meta[i] <= d[i];
               q[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### logic/isab_top.sv
/*
 ISA bus cycle engine: runs PCI-master and DMA cycles on the ISA pins,
 watches ISA-master strobes, derives bus and timer clocks.
 Assumes active-low ISA pins idle high (pulled up off chip) and one
 request held until done.
*/
// How it works
// RULE1: Memory read and write strobes are driven in PCI and DMA cycles and sensed for ISA masters.
// RULE2: I/O read and write strobes are driven in PCI and DMA cycles and sensed for ISA masters.
// RULE3: The bus owner drives upper address bits 23 to 17 for a 16M space.
// RULE4: Low address bits 16 to 0 carry memory addresses, 15 to 0 carry I/O addresses.
// RULE5: A zero-wait-state assertion ends the cycle before the ready count runs out.
// RULE6: Byte-high enable is asserted whenever the upper data lanes carry data.
// RULE7: A memory slave asserts the 16-bit memory select, else the cycle is 8-bit.
// RULE8: An I/O slave asserts the 16-bit I/O select to size the cycle to 16 bits.
// RULE9: A channel check assertion is reported as a bus error.
// RULE10: Refresh is only pulled low open-drain, and others may pull it too.
// RULE11: The low-memory strobes fire only for memory addresses below 1M.
// RULE12: The timer clock comes from the 14 MHz oscillator and the bus clock is driven out.
// RULE13: The master input is sampled and the strobes then turn to inputs.
// RULE14: A slave holding channel ready low stretches the cycle until it returns.
// RULE15: Address enable is asserted throughout DMA cycles.
// RULE16: Address latch enable pulses when a valid address is on the bus.
// RULE17: Address, byte-high and strobe drivers are released while an ISA master owns the bus; address and byte-high stay on until a running cycle ends.
`timescale 1ns/100ps
`default_nettype none
module isab_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire isab_pkg::isab_req_t req,
   output isab_pkg::isab_rsp_t rsp,
   output logic isa_master_active,
   output logic refresh_seen,
   input wire logic refresh_req,
   input wire logic osc,
   output logic timer_tick,
   output logic bclk,
   output logic [6:0] la_o,
   output logic la_oe,
   input wire logic [6:0] la_i,
   output logic [16:0] sa_o,
   output logic sa_oe,
   input wire logic [16:0] sa_i,
   output logic [15:0] sd_o,
   output logic sd_oe,
   input wire logic [15:0] sd_i,
   output logic memr_b_o,
   output logic memw_b_o,
   output logic ior_b_o,
   output logic iow_b_o,
   output logic strobe_oe,
   input wire logic memr_b_i,
   input wire logic memw_b_i,
   input wire logic ior_b_i,
   input wire logic iow_b_i,
   output logic smemr_b,
   output logic smemw_b,
   output logic sbhe_b_o,
   output logic sbhe_oe,
   input wire logic sbhe_b_i,
   input wire logic m16_b,
   input wire logic io16_b,
   input wire logic zws_b,
   input wire logic iochrdy,
   input wire logic iochk_b,
   input wire logic master_b,
   output logic refresh_b_oe,
   input wire logic refresh_b_i,
   output logic bale,
   output logic aen
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [8:0] raw_in;
   logic [8:0] sync_in;
   logic s_m16_b, s_io16_b, s_zws_b, s_rdy, s_chk_b, s_master_b, s_ref_b, s_osc, s_spare;
   assign raw_in = {m16_b, io16_b, zws_b, iochrdy, iochk_b, master_b, refresh_b_i, osc,
                    memr_b_i & memw_b_i & ior_b_i & iow_b_i};
   isab_sync #(.W(9)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(raw_in),
      .rst_val(9'h1ff),
      .q(sync_in)
   );
   assign {s_m16_b, s_io16_b, s_zws_b, s_rdy, s_chk_b, s_master_b, s_ref_b, s_osc,
           s_spare} = sync_in;
   logic [15:0] sd_sync;
   isab_sync #(.W(16)) u_sync_sd (.clk(clk), .rst_b(rst_b), .d(sd_i), .rst_val(16'hffff),
      .q(sd_sync));

   // ------------------------------------------------------------
   // Clocks
   // ------------------------------------------------------------
   logic [isab_pkg::CNT_W-1:0] bclk_cnt;
   logic osc_d;
   logic [3:0] osc_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bclk_cnt <= '0;
         bclk <= 1'b0;
      end else if (bclk_cnt == isab_pkg::CNT_W'(isab_pkg::BCLK_HALF_CYC - 1)) begin
         bclk_cnt <= '0;
         bclk <= ~bclk; // RULE12
      end else begin
         bclk_cnt <= bclk_cnt + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_d <= 1'b1;
         osc_cnt <= '0;
         timer_tick <= 1'b0;
      end else begin
         osc_d <= s_osc;
         timer_tick <= 1'b0;
         if (s_osc && !osc_d) begin
            if (osc_cnt == 4'(isab_pkg::TIMER_DIV - 1)) begin
               osc_cnt <= '0;
               timer_tick <= 1'b1; // RULE12
            end else begin
               osc_cnt <= osc_cnt + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Cycle engine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ALE = 3'b001,
      ST_CMD = 3'b010,
      ST_WAIT = 3'b011,
      ST_DONE = 3'b100,
      ST_EXT = 3'b101
   } isab_state_t;
   isab_state_t state;
   isab_pkg::isab_req_t cur;
   logic [isab_pkg::CNT_W-1:0] cnt;
   logic is_mem, is_wr, low_meg, ext_owner;
   assign is_mem = (cur.kind == isab_pkg::KIND_MEM_RD) || (cur.kind == isab_pkg::KIND_MEM_WR);
   assign is_wr = (cur.kind == isab_pkg::KIND_MEM_WR) || (cur.kind == isab_pkg::KIND_IO_WR);
   assign low_meg = cur.addr < isab_pkg::LOW_MEG_LIMIT;
   assign ext_owner = !s_master_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cur <= '0;
         cnt <= '0;
         rsp <= '0;
      end else begin
         rsp.done <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (ext_owner) begin
                  state <= ST_EXT; // RULE13
               end else if (req_valid) begin
                  cur <= req;
                  cnt <= '0;
                  state <= ST_ALE;
               end
            end
            ST_ALE: begin
               cnt <= cnt + 1'b1;
               if (cnt == isab_pkg::CNT_W'(isab_pkg::ALE_CYC - 1)) begin
                  cnt <= '0;
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               rsp.width16 <= is_mem ? !s_m16_b : !s_io16_b; // RULE7 RULE8
               cnt <= cnt + 1'b1;
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               cnt <= (cnt == '1) ? cnt : cnt + 1'b1;
               if (!s_zws_b && s_rdy) begin
                  state <= ST_DONE; // RULE5
               end else if (cnt >= isab_pkg::CNT_W'(isab_pkg::READY_CYC - 1) && s_rdy) begin
                  state <= ST_DONE; // RULE14
               end
            end
            ST_DONE: begin
               rsp.done <= 1'b1;
               rsp.rdata <= sd_sync;
               rsp.err <= !s_chk_b; // RULE9
               state <= ST_IDLE;
            end
            ST_EXT: begin
               if (!ext_owner) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   logic busy, strobe;
   assign busy = (state != ST_IDLE) && (state != ST_EXT);
   assign strobe = (state == ST_CMD) || (state == ST_WAIT);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         la_o <= '0;
         sa_o <= '0;
         sd_o <= '0;
         la_oe <= 1'b0;
         sa_oe <= 1'b0;
         sd_oe <= 1'b0;
         sbhe_oe <= 1'b0;
         strobe_oe <= 1'b0;
         sbhe_b_o <= 1'b1;
         memr_b_o <= 1'b1;
         memw_b_o <= 1'b1;
         ior_b_o <= 1'b1;
         iow_b_o <= 1'b1;
         smemr_b <= 1'b1;
         smemw_b <= 1'b1;
         bale <= 1'b0;
         aen <= 1'b0;
      end else begin
         la_o <= is_mem ? cur.addr[23:17] : 7'h00; // RULE3
         sa_o <= is_mem ? cur.addr[16:0] : {1'b0, cur.addr[15:0]}; // RULE4
         sd_o <= cur.wdata;
         la_oe <= busy; // RULE17
         sa_oe <= busy;
         sbhe_oe <= busy;
         strobe_oe <= busy && !ext_owner; // RULE1 RULE2 RULE13
         sd_oe <= busy && is_wr;
         sbhe_b_o <= !(busy && cur.hi_lane); // RULE6
         memr_b_o <= !(strobe && cur.kind == isab_pkg::KIND_MEM_RD); // RULE1
         memw_b_o <= !(strobe && cur.kind == isab_pkg::KIND_MEM_WR);
         ior_b_o <= !(strobe && cur.kind == isab_pkg::KIND_IO_RD); // RULE2
         iow_b_o <= !(strobe && cur.kind == isab_pkg::KIND_IO_WR);
         smemr_b <= !(strobe && cur.kind == isab_pkg::KIND_MEM_RD && low_meg); // RULE11
         smemw_b <= !(strobe && cur.kind == isab_pkg::KIND_MEM_WR && low_meg);
         bale <= (state == ST_ALE); // RULE16
         aen <= busy && cur.dma; // RULE15
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_b_oe <= 1'b0;
         refresh_seen <= 1'b0;
         isa_master_active <= 1'b0;
      end else begin
         refresh_b_oe <= refresh_req; // RULE10
         refresh_seen <= !s_ref_b;
         isa_master_active <= ext_owner; // RULE13
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [isab_pkg::CNT_W-1:0] bale_run;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bale_run <= '0;
      end else begin
         bale_run <= bale ? bale_run + 1'b1 : '0;
      end
   end
   sequence s_ale_phase;
      !bale && bale_run == isab_pkg::CNT_W'(isab_pkg::ALE_CYC);
   endsequence
   AST_STROBE_RELEASE: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
      isa_master_active |-> !strobe_oe) else $error("strobes driven under isa master");
   AST_SMEM_HIGH: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
      (state == ST_WAIT && !low_meg) |=> smemr_b && smemw_b) else $error("low strobe above 1M");
   AST_AEN_DMA: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
      (busy && cur.dma) |=> aen) else $error("aen missing in dma");
   AST_ZWS_END: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
      (state == ST_WAIT && !s_zws_b && s_rdy) |=> state == ST_DONE) else $error("zws ignored");
   AST_RDY_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
      (state == ST_WAIT && !s_rdy) |=> state == ST_WAIT) else $error("ready not honoured");
   AST_BALE_PULSE: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
      $fell(bale) |-> s_ale_phase) else $error("bale pulse length");
   AST_IOR_OUT: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
      !ior_b_o |-> strobe_oe) else $error("ior driven low with drivers off");
   AST_MEMR_OUT: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
      !memr_b_o |-> strobe_oe) else $error("memr driven low with drivers off");
   AST_ERR: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
      (state == ST_DONE && !s_chk_b) |=> rsp.err && rsp.done) else $error("error not reported");
   AST_SBHE: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
      (busy && cur.hi_lane) |=> !sbhe_b_o) else $error("sbhe missing");
endmodule
`default_nettype wire

// ### bench/isab_slave_model.sv
/*
 ISA slave card model: answers strobes, reports width, ends early or stretches.
 Assumes the bench sets its behaviour on the mode inputs between cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module isab_slave_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] strb_b,
   input wire logic [16:0] sa,
   input wire logic fast,
   input wire logic [7:0] hold,
   input wire logic wide,
   input wire logic chk,
   output logic m16_b,
   output logic io16_b,
   output logic zws_b,
   output logic iochrdy,
   output logic iochk_b,
   output logic [15:0] sd
);
   logic [7:0] cnt;
   logic [15:0] last;
   logic act;
   logic rd;
   assign act = ~&strb_b;
   assign rd = ~strb_b[3] | ~strb_b[1];
   assign m16_b = ~wide;
   assign io16_b = ~wide;
   assign iochk_b = ~chk;
   assign iochrdy = !(act && cnt < hold);
   assign zws_b = !(act && fast && cnt >= 8'h02);
   assign sd = (act && rd) ? (sa[15:0] ^ 16'h3c5a) : ~last;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
         last <= 16'h0000;
      end else begin
         cnt <= !act ? 8'h00 : (cnt == 8'hff ? cnt : cnt + 8'h01);
         last <= sd;
      end
   end
endmodule
`default_nettype wire

// ### bench/test_isa_bus_cycle_interface.sv
/*
 Bench for the ISA bus cycle engine: queued expectations, pin monitor.
 Assumes the slave model on the far side and a 200 MHz core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module test_isa_bus_cycle_interface;
   typedef struct {logic rd; logic w16; logic err; logic [15:0] rdata;
                   int lo; int hi; int t0;} isab_note_t;
   logic clk = 0, rst_b = 0, req_valid = 0, osc = 0, refresh_req = 0, master_b = 1, ext_ref = 0;
   logic fast = 0, wide = 0, chk_in = 0, seen = 0;
   logic [7:0] hold = 8'h00;
   logic [3:0] ext_strb = 4'hf;
   logic [23:0] ext_addr = 24'h000000;
   isab_pkg::isab_req_t req = '0, cur = '0, r;
   isab_pkg::isab_rsp_t rsp;
   logic isa_master_active, refresh_seen, timer_tick, bclk, la_oe, sa_oe, sd_oe, strobe_oe;
   logic memr_b_o, memw_b_o, ior_b_o, iow_b_o, smemr_b, smemw_b, sbhe_b_o, sbhe_oe;
   logic refresh_b_oe, bale, aen, m16_b, io16_b, zws_b, iochrdy, iochk_b;
   logic [6:0] la_o;
   logic [16:0] sa_o;
   logic [15:0] sd_o, sd_i;
   isab_note_t notes[$], n;
   int num_errors = 0, checks_done = 0, cyc = 0, bale_cnt = 0, tick_cnt = 0, seed, i;
   real t;
   // ------------------------------------------------------------
   // Clocks and instances
   // ------------------------------------------------------------
   initial forever #2.5 clk = ~clk;
   initial begin
      #3;
      forever #24 osc = ~osc;
   end
   always @(posedge clk) begin
      cyc++;
      if (timer_tick === 1'b1) tick_cnt++;
   end
   isab_top u_isab_top (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .rsp(rsp),
      .isa_master_active(isa_master_active), .refresh_seen(refresh_seen),
      .refresh_req(refresh_req), .osc(osc), .timer_tick(timer_tick), .bclk(bclk),
      .la_o(la_o), .la_oe(la_oe), .la_i(la_oe ? la_o : ext_addr[23:17]),
      .sa_o(sa_o), .sa_oe(sa_oe), .sa_i(sa_oe ? sa_o : ext_addr[16:0]),
      .sd_o(sd_o), .sd_oe(sd_oe), .sd_i(sd_oe ? sd_o : sd_i),
      .memr_b_o(memr_b_o), .memw_b_o(memw_b_o), .ior_b_o(ior_b_o), .iow_b_o(iow_b_o),
      .strobe_oe(strobe_oe), .memr_b_i(strobe_oe ? memr_b_o : ext_strb[3]),
      .memw_b_i(strobe_oe ? memw_b_o : ext_strb[2]), .ior_b_i(strobe_oe ? ior_b_o : ext_strb[1]),
      .iow_b_i(strobe_oe ? iow_b_o : ext_strb[0]), .smemr_b(smemr_b), .smemw_b(smemw_b),
      .sbhe_b_o(sbhe_b_o), .sbhe_oe(sbhe_oe), .sbhe_b_i(sbhe_oe ? sbhe_b_o : ext_addr[0]),
      .m16_b(m16_b), .io16_b(io16_b), .zws_b(zws_b), .iochrdy(iochrdy), .iochk_b(iochk_b),
      .master_b(master_b), .refresh_b_oe(refresh_b_oe), .refresh_b_i(!(refresh_b_oe | ext_ref)),
      .bale(bale), .aen(aen));
   isab_slave_model u_isab_slave_model (.clk(clk), .rst_b(rst_b),
      .strb_b(strobe_oe ? {memr_b_o, memw_b_o, ior_b_o, iow_b_o} : 4'hf), .sa(sa_o),
      .fast(fast), .hold(hold), .wide(wide), .chk(chk_in), .m16_b(m16_b), .io16_b(io16_b),
      .zws_b(zws_b), .iochrdy(iochrdy), .iochk_b(iochk_b), .sd(sd_i));
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(negedge clk) begin
      if (rsp.done === 1'b1) begin
         if (notes.size() == 0) chk(32'h1, 32'h0);
         else begin
            n = notes.pop_front();
            chk({rsp.width16, rsp.err}, {n.w16, n.err});
            if (n.rd) chk(rsp.rdata, n.rdata);
            chk(32'(cyc - n.t0 >= n.lo && cyc - n.t0 <= n.hi), 32'h1);
         end
      end
   end
   always @(negedge clk) begin
      if (bale === 1'b1) bale_cnt++;
      if (strobe_oe === 1'b1 && {memr_b_o, memw_b_o, ior_b_o, iow_b_o} !== 4'hf && !seen) begin
         seen = 1;
         chk(bale_cnt, isab_pkg::ALE_CYC);
         chk({memr_b_o, memw_b_o, ior_b_o, iow_b_o}, 4'hf ^ (4'h8 >> cur.kind));
         chk({la_oe, la_o}, {1'b1, cur.kind[1] ? 7'h00 : cur.addr[23:17]});
         chk({sa_oe, sa_o & (cur.kind[1] ? 17'h0ffff : 17'h1ffff)},
            {1'b1, cur.addr[16:0] & (cur.kind[1] ? 17'h0ffff : 17'h1ffff)});
         chk({sbhe_oe, sbhe_b_o}, {1'b1, ~cur.hi_lane});
         chk(aen, cur.dma);
         chk({smemr_b, smemw_b}, (!cur.kind[1] && cur.addr < isab_pkg::LOW_MEG_LIMIT) ?
            {cur.kind[0], ~cur.kind[0]} : 2'b11);
         if (cur.kind[0]) chk({sd_oe, sd_o}, {1'b1, cur.wdata});
      end
   end
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   task automatic run(input isab_pkg::isab_req_t q, input logic f, input logic [7:0] h,
                      input logic w, input logic c, input int lo, input int hi);
      int k;
      @(negedge clk);
      fast = f;
      hold = h;
      wide = w;
      chk_in = c;
      req = q;
      cur = q;
      notes.push_back('{~q.kind[0], w, c, q.addr[15:0] ^ 16'h3c5a, lo, hi, cyc});
      bale_cnt = 0;
      seen = 0;
      req_valid = 1;
      k = 0;
      while (rsp.done !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      req_valid = 0;
      if (k == 400) chk(32'h0, 32'h1);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #60000;
      num_errors++;
      results;
   end
   initial begin
      seed = 71;
      repeat (2) @(negedge clk);
      rst_b = 1;
      repeat (3) @(negedge clk);
      chk({strobe_oe, la_oe, sa_oe, sd_oe, bale, aen, smemr_b, smemw_b, refresh_b_oe}, 9'h006);
      for (i = 0; i < 8; i++) begin
         r = isab_pkg::isab_req_t'({13'($random(seed)), $random(seed)});
         r.dma = i[2];
         r.kind = isab_pkg::isab_kind_t'(i[1:0]);
         r.addr = (i == 1) ? 24'h0fffff : (i == 4) ? 24'h100000 : r.addr;
         if (i == 0) r.addr[23:20] = 4'h0;
         run(r, 1'b1, 8'h00, r.wide, 1'b0, 14, 45);
      end
      r.kind = isab_pkg::KIND_MEM_RD;
      run(r, 1'b0, 8'h00, 1'b0, 1'b1, isab_pkg::READY_CYC, isab_pkg::READY_CYC + 40);
      r.kind = isab_pkg::KIND_IO_RD;
      run(r, 1'b0, 8'd200, 1'b1, 1'b0, 200, 300);
      @(negedge clk);
      master_b = 0;
      ext_strb = 4'h7;
      ext_addr = 24'($random(seed));
      repeat (4) @(negedge clk);
      req = r;
      req_valid = 1;
      repeat (150) @(negedge clk);
      chk({isa_master_active, strobe_oe, la_oe, sa_oe, sbhe_oe}, 5'h10);
      req_valid = 0;
      master_b = 1;
      ext_strb = 4'hf;
      repeat (6) @(negedge clk);
      chk(isa_master_active, 1'b0);
      run(r, 1'b1, 8'h00, 1'b1, 1'b0, 14, 45);
      refresh_req = 1;
      repeat (6) @(negedge clk);
      chk({refresh_b_oe, refresh_seen}, 2'h3);
      refresh_req = 0;
      ext_ref = 1;
      repeat (6) @(negedge clk);
      chk({refresh_b_oe, refresh_seen}, 2'h1);
      ext_ref = 0;
      @(posedge bclk);
      t = $realtime;
      @(posedge bclk);
      chk(32'($rtoi(($realtime - t) * 10.0)), 32'd1200);
      @(negedge osc);
      tick_cnt = 0;
      repeat (48) @(negedge osc);
      chk(tick_cnt, 32'd4);
      results;
   end
endmodule
`default_nettype wire
